//--- src/dpdc_top.sv
// Dual prescaled down-counter: two timer channels, their control
// registers, the external timer input and the toggling timer output.
// Assumes a synchronous byte register port on core_clk and an
// asynchronous timer_in pin.
// Requests leave as one-cycle pulses.
//
// How it works
// RULE1 - Two 8-bit counters, each with 6-bit prescaler
// RULE2 - Internal clock both; external clock second only
// RULE3 - Prescaler divides source by 1 to 64
// RULE4 - Prescaler decrements counter from loaded 0..255
// RULE5 - End-of-count raises counter's own request line
// RULE6 - Software starts, stops, continues or reloads counters
// RULE7 - Halt at end-of-count or auto-reload
// RULE8 - Reading count never disturbs count or mode
// RULE9 - External input: clock, trigger, retrigger, or gate
// RULE10 - External count clock kept at most 1 MHz
// RULE11 - Timer output carries counter A, B, or clock
// RULE12 - Timer output toggles at selected end-of-count
// RULE13 - Auto-reload makes a 50% square wave
// RULE14 - Timer output may feed timer input, cascading
// RULE15 - Counters run with no processor involvement
// RULE16 - Reload on tick after end-of-count
// RULE17 - Stopped counter holds prescaler and count
`timescale 1ns/10ps
`default_nettype none
module dpdc_top
    import dpdc_pkg::*;
#(
    parameter int INT_DIV = dpdc_pkg::DPDC_INT_DIV
) (
    // Clock, reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [dpdc_pkg::DPDC_DW-1:0] reg_wdata,
    output logic [dpdc_pkg::DPDC_DW-1:0] reg_rdata_q,
    // Timer pins
    input wire logic timer_in,
    output logic timer_out_q,
    output logic counter_a_request_q,
    output logic counter_b_request_q
);
    import dpdc_pkg::*;

    // Register contents
    // All reset to zero
    logic [DPDC_DW-1:0] mode_q; // Mode control, load bits kept clear
    logic [DPDC_CW-1:0] cnt_a_init_q; // Counter A initial value
    logic [DPDC_CW-1:0] cnt_b_init_q; // Counter B initial value
    logic [DPDC_DW-1:0] pre_a_q; // Prescaler A load register
    logic [DPDC_DW-1:0] pre_b_q; // Prescaler B load register

    // Register port decode
    logic wr_mode; // Write to mode control
    logic wr_cnt_a; // Write to counter A load
    logic wr_cnt_b; // Write to counter B load
    logic wr_pre_a; // Write to prescaler A load
    logic wr_pre_b; // Write to prescaler B load
    logic [DPDC_DW-1:0] rd_mux; // Read data before its register

    // Mode fields
    logic en_a; // Counter A running
    logic en_b; // Counter B running
    logic [1:0] in_mode; // External input function
    logic [1:0] out_sel; // Timer output source
    logic sw_load_a; // Software load pulse, counter A
    logic sw_load_b; // Software load pulse, counter B

    // Prescaler fields
    logic [DPDC_PW-1:0] div_a; // Divisor A
    logic [DPDC_PW-1:0] div_b; // Divisor B
    logic reload_a; // Counter A auto-reload
    logic reload_b; // Counter B auto-reload
    logic b_int_clk; // Counter B on the internal clock

    // Internal count clock
    logic [$clog2(INT_DIV+1)-1:0] int_cnt_q; // Internal clock divider
    logic int_tick_q; // One pulse per internal clock period

    // External input path
    logic tin_s1_q; // First synchroniser stage
    logic tin_s2_q; // Second synchroniser stage
    logic tin_s3_q; // Edge detect history
    logic tin_fall; // Falling edge on the input
    logic trig_act_q; // Trigger has started counter B
    logic b_trig; // Accepted trigger edge
    logic b_gate_mode; // Gate function selected
    logic b_trig_mode; // Either trigger function selected

    // Channel wiring
    // Pulses last one cycle
    logic src_b; // Source pulse for prescaler B
    logic run_a; // Channel A may count
    logic run_b; // Channel B may count
    logic load_a; // Load pulse channel A
    logic load_b; // Load pulse channel B
    logic [DPDC_CW-1:0] count_a; // Current count A
    logic [DPDC_CW-1:0] count_b; // Current count B
    logic eoc_a; // End-of-count pulse A
    logic eoc_b; // End-of-count pulse B
    logic out_toggle; // Timer output must flip

    // Address match helper used for every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // Write strobes
    // Strobes last one cycle
    // Unmapped: no strobe
    assign wr_mode = reg_wr & hit(reg_addr, DPDC_ADDR_MODE);
    assign wr_cnt_a = reg_wr & hit(reg_addr, DPDC_ADDR_CNT_A);
    assign wr_cnt_b = reg_wr & hit(reg_addr, DPDC_ADDR_CNT_B);
    assign wr_pre_a = reg_wr & hit(reg_addr, DPDC_ADDR_PRE_A);
    assign wr_pre_b = reg_wr & hit(reg_addr, DPDC_ADDR_PRE_B);

    // Mode field extraction
    assign en_a = mode_q[DPDC_MODE_EN_A];
    assign en_b = mode_q[DPDC_MODE_EN_B];
    // Two-bit fields
    assign in_mode = mode_q[DPDC_MODE_IN_LO +: 2];
    assign out_sel = mode_q[DPDC_MODE_OUT_LO +: 2];
    // Load bits act on the write itself and never stay set [RULE6]
    assign sw_load_a = wr_mode & reg_wdata[DPDC_MODE_LOAD_A];
    assign sw_load_b = wr_mode & reg_wdata[DPDC_MODE_LOAD_B];

    // Prescaler field extraction [RULE3]
    assign div_a = pre_a_q[DPDC_PRE_DIV_LO +: DPDC_PW];
    assign div_b = pre_b_q[DPDC_PRE_DIV_LO +: DPDC_PW];
    // Divisor 0 means 64
    // Stop or reload choice per channel [RULE7]
    assign reload_a = pre_a_q[DPDC_PRE_RELOAD];
    assign reload_b = pre_b_q[DPDC_PRE_RELOAD];
    // Only channel B may leave the internal clock [RULE2]
    assign b_int_clk = pre_b_q[DPDC_PRE_CLK_INT];

    // Read mux; counter addresses show the live count [RULE8]
    always_comb begin
        // Live counts
        if (hit(reg_addr, DPDC_ADDR_MODE)) begin
            rd_mux = mode_q;
        end else if (hit(reg_addr, DPDC_ADDR_CNT_B)) begin
            rd_mux = count_b;
        end else if (hit(reg_addr, DPDC_ADDR_PRE_B)) begin
            rd_mux = pre_b_q;
        end else if (hit(reg_addr, DPDC_ADDR_CNT_A)) begin
            rd_mux = count_a;
        end else if (hit(reg_addr, DPDC_ADDR_PRE_A)) begin
            rd_mux = pre_a_q;
        end else begin
            // Unmapped numbers read as zero
            rd_mux = DPDC_RST_BYTE;
        end
    end

    // Registered read data, no side effect on any state [RULE8]
    // One cycle latency
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata_q <= DPDC_RST_BYTE;
        end else begin
            reg_rdata_q <= rd_mux;
        end
    end

    // Mode control; load bits are stored as zero [RULE6]
    // Enables act at once
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mode_q <= DPDC_RST_BYTE;
        end else if (wr_mode) begin
            mode_q <= reg_wdata & ~(DPDC_DW'(1) << DPDC_MODE_LOAD_A)
                                & ~(DPDC_DW'(1) << DPDC_MODE_LOAD_B);
        end
    end

    // Initial values for the counters [RULE4]
    // Used on load and on auto-reload
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_a_init_q <= DPDC_RST_BYTE;
            cnt_b_init_q <= DPDC_RST_BYTE;
        end else begin
            if (wr_cnt_a) begin
                cnt_a_init_q <= reg_wdata;
            end
            if (wr_cnt_b) begin
                cnt_b_init_q <= reg_wdata;
            end
        end
    end

    // Prescaler load registers
    // Divisor, source, reload
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pre_a_q <= DPDC_RST_BYTE;
            pre_b_q <= DPDC_RST_BYTE;
        end else begin
            if (wr_pre_a) begin
                pre_a_q <= reg_wdata;
            end
            if (wr_pre_b) begin
                pre_b_q <= reg_wdata;
            end
        end
    end

    // Internal count clock from the core clock [RULE2]
    // One-cycle pulse
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            int_cnt_q <= '0;
            int_tick_q <= 1'b0;
        end else if (int_cnt_q == $bits(int_cnt_q)'(INT_DIV - 1)) begin
            int_cnt_q <= '0;
            int_tick_q <= 1'b1;
        end else begin
            int_cnt_q <= int_cnt_q + $bits(int_cnt_q)'(1);
            int_tick_q <= 1'b0;
        end
    end

    // Timer input synchroniser plus edge history; s2 and s3 feed logic
    // Stage s3 feeds edge detect
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tin_s1_q <= 1'b0;
            tin_s2_q <= 1'b0;
            tin_s3_q <= 1'b0;
        end else begin
            tin_s1_q <= timer_in;
            tin_s2_q <= tin_s1_q;
            tin_s3_q <= tin_s2_q;
        end
    end

    // Falling edge; source kept at or below 1 MHz by its driver [RULE10]
    // Reset 0: no false fall
    assign tin_fall = tin_s3_q & ~tin_s2_q;

    // External input functions when B runs on the internal clock [RULE9]
    assign b_gate_mode = b_int_clk & (in_mode == DPDC_IN_GATE);
    assign b_trig_mode = b_int_clk & ((in_mode == DPDC_IN_TRIG)
                                    | (in_mode == DPDC_IN_RETRIG));
    // Retrigger always reloads; plain trigger only when idle [RULE9]
    assign b_trig = b_trig_mode & en_b & tin_fall
                  & ((in_mode == DPDC_IN_RETRIG) | ~trig_act_q);

    // Trigger state: set by an accepted edge, ends with a single pass
    // New edge wins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trig_act_q <= 1'b0;
        end else if (b_trig) begin
            trig_act_q <= 1'b1;
        end else if (~b_trig_mode | (eoc_b & ~reload_b)) begin
            trig_act_q <= 1'b0;
        end
    end

    // Clock source for prescaler B, cascade via the input pin [RULE2]
    // Timer output wired back to timer_in chains the counters [RULE14]
    // Edges act 3 cycles late
    assign src_b = b_int_clk ? int_tick_q : tin_fall;

    // Run conditions; enable bit starts and stops, keeping state [RULE6]
    // Gate reads s2 level
    assign run_a = en_a;
    assign run_b = en_b & (b_gate_mode ? tin_s2_q : 1'b1)
                        & (b_trig_mode ? trig_act_q : 1'b1);
    // Restart from the initial value [RULE6]
    assign load_a = sw_load_a;
    assign load_b = sw_load_b | b_trig;

    // Channel A on the internal clock, free of software once set [RULE15]
    // Halt kept inside
    dpdc_chan #(
        .CW(DPDC_CW),
        .PW(DPDC_PW)
    ) u_chan_a (
        .core_clk(core_clk),
        .rstn(rstn),
        .src_tick(int_tick_q),
        .run(run_a),
        .load(load_a),
        .reload_mode(reload_a),
        .init_val(cnt_a_init_q),
        .div_val(div_a),
        .count_q(count_a),
        .halted_q(),
        .eoc(eoc_a)
    );

    // Channel B, internal or external source [RULE1]
    // Triggers load it
    dpdc_chan #(
        .CW(DPDC_CW),
        .PW(DPDC_PW)
    ) u_chan_b (
        .core_clk(core_clk),
        .rstn(rstn),
        .src_tick(src_b),
        .run(run_b),
        .load(load_b),
        .reload_mode(reload_b),
        .init_val(cnt_b_init_q),
        .div_val(div_b),
        .count_q(count_b),
        .halted_q(),
        .eoc(eoc_b)
    );

    // End-of-count requests, one cycle each [RULE5]
    // Glitch-free pins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            counter_a_request_q <= 1'b0;
            counter_b_request_q <= 1'b0;
        end else begin
            counter_a_request_q <= eoc_a;
            counter_b_request_q <= eoc_b;
        end
    end

    // Output source select [RULE11]
    // Select 0 holds
    assign out_toggle = ((out_sel == DPDC_OUT_A) & eoc_a)
                      | ((out_sel == DPDC_OUT_B) & eoc_b)
                      | ((out_sel == DPDC_OUT_INT) & int_tick_q);

    // Toggle per end-of-count; equal reload periods give 50% [RULE12]
    // Half periods match in auto-reload mode [RULE13]
    // Starts low
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            timer_out_q <= 1'b0;
        end else if (out_toggle) begin
            timer_out_q <= ~timer_out_q;
        end
    end
endmodule
`default_nettype wire

//--- src/dpdc_pkg.sv
// Constants shared by the dual prescaled down-counter block.
// Assumes a byte-wide register port addressed by the 8-bit register number.
package dpdc_pkg;
    // Data widths
    localparam int DPDC_DW = 8;
    localparam int DPDC_CW = 8;
    localparam int DPDC_PW = 6;
    // Register numbers in the control register page
    localparam logic [7:0] DPDC_ADDR_MODE = 8'hF1;
    localparam logic [7:0] DPDC_ADDR_CNT_B = 8'hF2;
    localparam logic [7:0] DPDC_ADDR_PRE_B = 8'hF3;
    localparam logic [7:0] DPDC_ADDR_CNT_A = 8'hF4;
    localparam logic [7:0] DPDC_ADDR_PRE_A = 8'hF5;
    // Mode control fields
    localparam int DPDC_MODE_LOAD_A = 0;
    localparam int DPDC_MODE_EN_A = 1;
    localparam int DPDC_MODE_LOAD_B = 2;
    localparam int DPDC_MODE_EN_B = 3;
    localparam int DPDC_MODE_IN_LO = 4;
    localparam int DPDC_MODE_OUT_LO = 6;
    // Prescaler load fields
    localparam int DPDC_PRE_RELOAD = 0;
    localparam int DPDC_PRE_CLK_INT = 1;
    localparam int DPDC_PRE_DIV_LO = 2;
    // External input function (internal clock source only)
    localparam logic [1:0] DPDC_IN_NONE = 2'h0;
    localparam logic [1:0] DPDC_IN_GATE = 2'h1;
    localparam logic [1:0] DPDC_IN_TRIG = 2'h2;
    localparam logic [1:0] DPDC_IN_RETRIG = 2'h3;
    // Timer output source
    localparam logic [1:0] DPDC_OUT_OFF = 2'h0;
    localparam logic [1:0] DPDC_OUT_A = 2'h1;
    localparam logic [1:0] DPDC_OUT_B = 2'h2;
    localparam logic [1:0] DPDC_OUT_INT = 2'h3;
    // Reset values
    localparam logic [7:0] DPDC_RST_BYTE = 8'h00;
    // Core clock and internal count clock
    localparam int DPDC_CORE_MHZ = 25;
    localparam int DPDC_INT_DIV = 4;
    // Highest external count rate, and the least input period it implies
    localparam int DPDC_EXT_MAX_KHZ = 1000;
    localparam int DPDC_EXT_MIN_CYC =
        (DPDC_CORE_MHZ * 1000 + DPDC_EXT_MAX_KHZ - 1) / DPDC_EXT_MAX_KHZ;
endpackage

//--- src/dpdc_chan.sv
// One prescaler plus 8-bit down-counter channel.
// Assumes src_tick is a one-cycle pulse on core_clk; load wins over ticks.
`timescale 1ns/10ps
`default_nettype none
module dpdc_chan #(
    parameter int CW = 8,
    parameter int PW = 6
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic src_tick,
    input wire logic run,
    input wire logic load,
    input wire logic reload_mode,
    input wire logic [CW-1:0] init_val,
    input wire logic [PW-1:0] div_val,
    output logic [CW-1:0] count_q,
    output logic halted_q,
    output logic eoc
);
    logic [PW-1:0] pre_q; // Prescaler down-count, 0 means 64
    logic active; // Counting allowed this cycle
    logic pre_tick; // Prescaler output pulse
    logic [CW-1:0] cnt_next; // Count after a prescaler tick
    logic cnt_zero; // Counter sits at end-of-count

    // Stopped or halted channel holds everything [RULE17]
    assign active = run & ~halted_q;
    // Divide by div_val, 0 giving the full 64 [RULE3]
    assign pre_tick = active & src_tick & (pre_q == PW'(1));
    assign cnt_zero = (count_q == '0);
    // Reload on the tick after end-of-count, no tick lost [RULE16]
    assign cnt_next = cnt_zero ? (reload_mode ? init_val : '0)
                               : count_q - CW'(1);
    // End-of-count when the count lands on zero [RULE5]
    assign eoc = pre_tick & ~load & (cnt_next == '0);

    // Prescaler stage [RULE1]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pre_q <= '0;
        end else if (load) begin
            pre_q <= div_val;
        end else if (pre_tick) begin
            pre_q <= div_val;
        end else if (active & src_tick) begin
            pre_q <= pre_q - PW'(1);
        end
    end

    // Down-counter, decremented by the prescaler [RULE4]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= init_val;
        end else if (pre_tick) begin
            count_q <= cnt_next;
        end
    end

    // Single-pass mode halts at end-of-count [RULE7]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            halted_q <= 1'b0;
        end else if (load) begin
            halted_q <= 1'b0;
        end else if (eoc & ~reload_mode) begin
            halted_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- test/dpdc_top_properties.sv
// Port checker for the dual prescaled down-counter.
// Assumes binding into dpdc_top; mode writes are shadowed here.
`timescale 1ns/10ps
`default_nettype none
module dpdc_top_properties
    import dpdc_pkg::*;
#(
    parameter int INT_DIV = 4
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DPDC_DW-1:0] reg_wdata,
    input wire logic [DPDC_DW-1:0] reg_rdata_q,
    input wire logic timer_in,
    input wire logic timer_out_q,
    input wire logic counter_a_request_q,
    input wire logic counter_b_request_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [7:0] mode_q; // Shadow of the mode byte
    logic [7:0] gap_q; // Cycles since request A, saturating
    logic wr_mode; // Mode write this cycle
    logic [1:0] sel; // Timer output source
    assign wr_mode = reg_wr && (reg_addr == DPDC_ADDR_MODE);
    assign sel = mode_q[7:6];
    // Shadow mode byte, time the gap between requests A
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mode_q <= 8'h00;
            gap_q <= 8'hFF;
        end else begin
            if (wr_mode) mode_q <= reg_wdata;
            if (counter_a_request_q) gap_q <= 8'h00;
            else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
        end
    end
    a_reset_quiet: assert property (
        $rose(rstn) |-> !(timer_out_q || counter_a_request_q
            || counter_b_request_q))
        else $error("output active after reset");
    a_req_a_pulse: assert property (
        counter_a_request_q |=> !counter_a_request_q)
        else $error("request A longer than a cycle");
    a_req_b_pulse: assert property (
        counter_b_request_q |=> !counter_b_request_q)
        else $error("request B longer than a cycle");
    a_out_cause: assert property (
        (timer_out_q != $past(timer_out_q)) && (sel != DPDC_OUT_INT)
        |-> (sel == DPDC_OUT_A && counter_a_request_q)
            || (sel == DPDC_OUT_B && counter_b_request_q))
        else $error("timer output toggled without cause");
    a_out_follow: assert property (
        sel == DPDC_OUT_A && counter_a_request_q
        |-> timer_out_q != $past(timer_out_q))
        else $error("timer output missed a toggle");
    a_mode_readback: assert property (
        wr_mode ##1 (reg_addr == DPDC_ADDR_MODE && !reg_wr)
        |=> reg_rdata_q == ($past(reg_wdata, 2) & 8'hFA))
        else $error("mode byte reads back wrong");
    a_pre_readback: assert property (
        (reg_wr && reg_addr == DPDC_ADDR_PRE_A)
        ##1 (reg_addr == DPDC_ADDR_PRE_A && !reg_wr)
        |=> reg_rdata_q == $past(reg_wdata, 2))
        else $error("prescaler A reads back wrong");
    a_hold_stopped: assert property (
        (!mode_q[DPDC_MODE_EN_A] && reg_addr == DPDC_ADDR_CNT_A
            && !reg_wr) [*4] |-> $stable(reg_rdata_q))
        else $error("stopped count A moved");
    a_req_needs_en: assert property (
        counter_a_request_q |-> $past(mode_q[DPDC_MODE_EN_A]))
        else $error("request A while stopped");
    a_gap_a: assert property (
        counter_a_request_q |-> gap_q >= 8'(INT_DIV - 1))
        else $error("requests A closer than a tick");
endmodule
bind dpdc_top dpdc_top_properties #(.INT_DIV(INT_DIV)) i_props (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .timer_in(timer_in), .timer_out_q(timer_out_q),
    .counter_a_request_q(counter_a_request_q),
    .counter_b_request_q(counter_b_request_q));
`default_nettype wire

//--- test/dpdc_ext_src.sv
// External timer input source for the counter block.
// Assumes the bench sets a half period of at least 13 core cycles.
`timescale 1ns/10ps
`default_nettype none
module dpdc_ext_src (
    input wire logic core_clk,
    input wire logic run,
    input wire logic loop,
    input wire logic level,
    input wire logic timer_out_q,
    input wire logic [7:0] half,
    output logic timer_in
);
    logic [7:0] cnt_q = 8'h00; // Cycles into this half period
    logic osc_q = 1'b1; // Square wave, still outside runs
    // Toggle each half period while running, else sit at level
    always @(posedge core_clk) begin
        if (!run) begin
            cnt_q <= 8'h00;
            osc_q <= level;
        end else if (cnt_q + 8'h01 >= half) begin
            cnt_q <= 8'h00;
            osc_q <= !osc_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // Loop mode feeds the timer output back in
    assign timer_in = loop ? timer_out_q : osc_q;
endmodule
`default_nettype wire

//--- test/dpdc_top_tb.sv
// Self-checking bench for the dual prescaled down-counter.
// Assumes the checker is bound in and dpdc_ext_src drives timer_in.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[ERR] %0t: got %0h exp %0h", $time, (got), (exp)); \
    end \
end
module dpdc_top_tb;
    import dpdc_pkg::*;
    localparam int DIV = 2; // Core cycles per internal tick
    logic core_clk = 1'b0; // 25 MHz core clock
    logic rstn = 1'b0; // Active-low reset
    logic [7:0] reg_addr = 8'h00; // Register number
    logic reg_wr = 1'b0; // Write strobe
    logic [7:0] reg_wdata = 8'h00; // Write data
    logic [7:0] reg_rdata_q; // Read data
    logic timer_in; // From the source model
    logic timer_out_q; // Timer output
    logic req_a; // Request A
    logic req_b; // Request B
    logic src_run = 1'b0; // Source oscillates
    logic src_loop = 1'b0; // Source loops output back
    logic src_lvl = 1'b1; // Source idle level
    logic [7:0] src_half = 8'h0F; // Source half period
    logic rd_go = 1'b0; // Read issued
    logic rd_p = 1'b0; // Read in flight
    logic rd_v = 1'b0; // Read data due
    logic [7:0] exp_v; // Oldest expected read
    logic [7:0] exp_q[$]; // Expected reads
    logic [31:0] seed = 32'h0000A2D4; // Xorshift state, 41684
    logic [1:0] trg[2] = '{DPDC_IN_TRIG, DPDC_IN_RETRIG}; // Triggers
    logic lvl; // Saved output level
    int n_mismatch = 0;
    int check_count = 0;
    int n, init, dv, hits;
    // Core clock
    initial forever #20 core_clk = ~core_clk;
    dpdc_top #(.INT_DIV(DIV)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .timer_in(timer_in), .timer_out_q(timer_out_q),
        .counter_a_request_q(req_a), .counter_b_request_q(req_b));
    dpdc_ext_src i_src (
        .core_clk(core_clk), .run(src_run), .loop(src_loop),
        .level(src_lvl), .timer_out_q(timer_out_q), .half(src_half),
        .timer_in(timer_in));
    // Pipeline the read marker to when its data is due
    always @(posedge core_clk) begin
        rd_p <= rd_go;
        rd_v <= rd_p;
    end
    // Compare due read data with the oldest note
    always @(negedge core_clk) begin
        if (rd_v) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata_q, exp_v)
        end
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic test_done();
        $display("TB: checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset();
        rstn = 1'b0;
        step(3);
        rstn = 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        exp_q.push_back(e);
        rd_go = 1'b1;
        step(1);
        rd_go = 1'b0;
        step(1);
    endtask
    // Count request pulses over a window
    task automatic quiet(input bit b, input int c);
        hits = 0;
        repeat (c) begin
            if ((b ? req_b : req_a) === 1'b1) hits++;
            step(1);
        end
    endtask
    // Wait for a request; w is cycles waited
    task automatic wait_req(input bit b, input int lim, output int w);
        w = 0;
        while ((b ? req_b : req_a) !== 1'b1) begin
            w++;
            if (w > lim) begin
                n_mismatch++;
                $display("[ERR] %0t: request never came", $time);
                test_done();
            end
            step(1);
        end
        step(1);
    endtask
    initial begin
        do_reset();
        for (int a = 0; a < 7; a++) rd(8'hF0 + 8'(a), 8'h00);
        init = rnd();
        wr(DPDC_ADDR_PRE_A, 8'(init));
        rd(DPDC_ADDR_PRE_A, 8'(init));
        wr(DPDC_ADDR_MODE, 8'(init) & 8'h3A);
        rd(DPDC_ADDR_MODE, 8'(init) & 8'h3A);
        $display("TB: register test done");
        for (int k = 0; k < 3; k++) begin
            do_reset();
            init = rnd() % 8;
            dv = (k == 2) ? 64 : rnd() % 4 + 1;
            wr(DPDC_ADDR_PRE_A, {dv[5:0], 2'b01});
            wr(DPDC_ADDR_CNT_A, 8'(init));
            wr(DPDC_ADDR_MODE, 8'h43);
            wait_req(1'b0, 1100, n);
            wait_req(1'b0, 1100, n);
            `CHK(n + 1, (init + 1) * dv * DIV)
            lvl = timer_out_q;
            wait_req(1'b0, 1100, n);
            `CHK(timer_out_q, ~lvl)
            `CHK(n + 1, (init + 1) * dv * DIV)
        end
        $display("TB: reload test done");
        do_reset();
        wr(DPDC_ADDR_PRE_A, 8'h04);
        wr(DPDC_ADDR_CNT_A, 8'h05);
        wr(DPDC_ADDR_MODE, 8'h01);
        rd(DPDC_ADDR_CNT_A, 8'h05);
        quiet(1'b0, 40);
        `CHK(hits, 0)
        wr(DPDC_ADDR_MODE, 8'h02);
        wait_req(1'b0, 40, n);
        `CHK(n >= 8, 1'b1)
        quiet(1'b0, 40);
        `CHK(hits, 0)
        rd(DPDC_ADDR_CNT_A, 8'h00);
        $display("TB: single pass test done");
        do_reset();
        src_run = 1'b1;
        wr(DPDC_ADDR_PRE_B, 8'h09);
        wr(DPDC_ADDR_CNT_B, 8'h01);
        wr(DPDC_ADDR_MODE, 8'h8C);
        wait_req(1'b1, 300, n);
        wait_req(1'b1, 300, n);
        `CHK(n + 1, 2 * 2 * 2 * src_half)
        do_reset();
        src_run = 1'b0;
        src_lvl = 1'b0;
        wr(DPDC_ADDR_PRE_B, 8'h07);
        wr(DPDC_ADDR_CNT_B, 8'h02);
        wr(DPDC_ADDR_MODE, 8'h9C);
        quiet(1'b1, 40);
        `CHK(hits, 0)
        src_lvl = 1'b1;
        wait_req(1'b1, 40, n);
        wait_req(1'b1, 40, n);
        `CHK(n + 1, 3 * DIV)
        foreach (trg[i]) begin
            do_reset();
            wr(DPDC_ADDR_PRE_B, 8'h06);
            wr(DPDC_ADDR_CNT_B, 8'h04);
            wr(DPDC_ADDR_MODE, {2'b00, trg[i], 4'h8});
            src_lvl = 1'b0;
            wait_req(1'b1, 60, n);
            `CHK(n >= 5 * DIV, 1'b1)
            quiet(1'b1, 40);
            `CHK(hits, 0)
            src_lvl = 1'b1;
        end
        $display("TB: timer input test done");
        do_reset();
        src_loop = 1'b1;
        wr(DPDC_ADDR_PRE_A, 8'h05);
        wr(DPDC_ADDR_CNT_A, 8'h0F);
        wr(DPDC_ADDR_PRE_B, 8'h05);
        wr(DPDC_ADDR_CNT_B, 8'h00);
        wr(DPDC_ADDR_MODE, 8'h4F);
        wait_req(1'b1, 300, n);
        wait_req(1'b1, 300, n);
        `CHK(n + 1, 2 * 16 * DIV)
        do_reset();
        src_loop = 1'b0;
        wr(DPDC_ADDR_MODE, 8'hC0);
        lvl = timer_out_q;
        hits = 0;
        repeat (8 * DIV) begin
            if (timer_out_q !== lvl) hits = 1;
            step(1);
        end
        `CHK(hits, 1)
        $display("TB: output test done");
        test_done();
    end
endmodule
`default_nettype wire
